//--- src/irq_wake_pkg.sv
// Constants, register map and carrier types for the interrupt and wakeup block
// Summary of operation
// [R1] Idle request bit stops execution, clock runs
// [R2] Idle request bit self-clears on wakeup
// [R3] In idle only the wakeup timer runs
// [R4] Idle wakeup resumes the mode entered from
// [R5] Idle exits on port change or timer overflow
// [R6] Power-down exits on port change, resumes normal
// [R7] Power-down wakeup waits 2048 or 32 clocks
// [R8] Idle wakeup has no warm-up delay
// [R9] Capture timer overflow never wakes idle
// [R10] Service entry clears global enable, exit sets
// [R11] Taking interrupt pushes stack, loads vector 8
// [R12] Return instruction pops program counter
// [R13] Enables at bits 0, 4 and 5
// [R14] Events set flags; software clears them
// [R15] Global enable bit 7 gates service, resets 0
// [R16] One-level save of accumulator and flags
// [R17] External pin event wakes power-down
// [R18] Pin flag sets even while disabled
// [R19] Edge select: 01 rise, 10 fall, 11 both
// [R20] Sleep request bit stops all, self-clears
// [R21] Vector only when global, enable, flag all set
package irq_wake_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] EDGE_CONFIG_IDX  = 8'hbf;
  localparam logic [7:0] REQ_FLAGS_IDX    = 8'hc8;
  localparam logic [7:0] ENABLES_IDX      = 8'hc9;
  localparam logic [7:0] OSC_MODE_IDX     = 8'hca;
  localparam logic [7:0] GIE_STACK_IDX    = 8'hdf;

  // Field positions
  localparam int PIN_BIT        = 0;
  localparam int BASIC_BIT      = 4;
  localparam int CAPTURE_BIT    = 5;
  localparam int GIE_BIT        = 7;
  localparam int IDLE_REQ_BIT   = 4;
  localparam int SLEEP_REQ_BIT  = 3;
  localparam int SLOW_BIT       = 2;
  localparam int STOP_HX_BIT    = 1;
  localparam int EDGE_LO_BIT    = 3;

  // Values after reset, and the mask of flag bits kept by a context save
  localparam logic [2:0] STACK_LEVEL_RST = 3'h7;
  localparam logic [1:0] EDGE_SEL_RST    = 2'h2;
  localparam logic [7:0] FLAG_SAVE_MASK  = 8'h3f;

  // Edge select encodings
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Warm-up counts in high-speed clocks, and the single vector
  localparam int          WARM_XTAL_CYCLES = 2048;
  localparam int          WARM_RC_CYCLES   = 32;
  localparam logic [13:0] IRQ_VECTOR       = 14'h0008;

  // Power states, Gray coded along run, sleep, warm-up
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_WARMUP = 2'b11,
    ST_IDLE   = 2'b10
  } pwr_state_t;

  // Requests from the CPU core
  typedef struct packed {
    logic        boundary;
    logic        return_from_irq;
    logic        push;
    logic        pop;
    logic [13:0] return_pc;
    logic [7:0]  acc;
    logic [7:0]  flags;
  } cpu_req_t;

  // Answers to the CPU core
  typedef struct packed {
    logic        run;
    logic        pc_load;
    logic        irq_taken;
    logic [13:0] pc_value;
    logic [7:0]  acc;
    logic [7:0]  flags;
  } cpu_rsp_t;

endpackage

//--- src/irq_and_idle_wakeup_ctrl.sv
// Interrupt controller with idle and power-down wakeup sequencing
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module irq_and_idle_wakeup_ctrl #(
  parameter int STACK_DEPTH = 8,
  parameter int WARM_XTAL   = irq_wake_pkg::WARM_XTAL_CYCLES,
  parameter int WARM_RC     = irq_wake_pkg::WARM_RC_CYCLES
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // CPU core
  input  wire irq_wake_pkg::cpu_req_t  cpu_req,
  output irq_wake_pkg::cpu_rsp_t       cpu_rsp,
  // Event sources; timer pulses are on pclk, ports are pins
  input  wire logic [7:0]              port_a,
  input  wire logic [7:0]              port_b,
  input  wire logic                    basic_timer_ovf,
  input  wire logic                    capture_timer_ovf,
  input  wire logic                    osc_is_rc,
  // Function gating
  output logic                         basic_timer_run,
  output logic                         functions_run,
  output logic                         hs_osc_run
);

  // Any pin of a port differs from its last sample
  function automatic logic port_changed(input logic [7:0] now_v,
                                        input logic [7:0] old_v);
    port_changed = |(now_v ^ old_v);
  endfunction

  // Pin synchronisers and previous samples
  logic [7:0] pa_meta_reg, pa_sync_reg, pa_prev_reg;
  logic [7:0] pb_meta_reg, pb_sync_reg, pb_prev_reg;
  logic       pin_seen_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pins idle high on their pull-ups; no false edge out of reset
      pa_meta_reg  <= 8'hff;
      pa_sync_reg  <= 8'hff;
      pa_prev_reg  <= 8'hff;
      pb_meta_reg  <= 8'hff;
      pb_sync_reg  <= 8'hff;
      pb_prev_reg  <= 8'hff;
      pin_seen_reg <= 1'b0;
    end else begin
      pa_meta_reg  <= port_a;
      pa_sync_reg  <= pa_meta_reg;
      pa_prev_reg  <= pa_sync_reg;
      pb_meta_reg  <= port_b;
      pb_sync_reg  <= pb_meta_reg;
      pb_prev_reg  <= pb_sync_reg;
      pin_seen_reg <= 1'b1; // Masks only the first cycle out of reset, when sync still equals prev
    end
  end

  // Registers
  logic [7:0]              flags_reg, flags_next;
  logic [7:0]              enables_reg;
  logic                    idle_req_reg, sleep_req_reg;
  logic                    slow_reg, stop_hx_reg;
  logic [1:0]              edge_sel_reg;
  logic                    gie_reg;
  logic [2:0]              level_reg;
  irq_wake_pkg::pwr_state_t state_reg, state_next;
  logic [11:0]             warm_cnt_reg;

  // Event detection
  logic port_change, ext_rise, ext_fall, ext_event, wake_idle;
  logic warm_done, take_irq;
  logic [11:0] warm_last;

  always_comb begin
    port_change = pin_seen_reg &
                  (port_changed(pa_sync_reg, pa_prev_reg) |
                   port_changed(pb_sync_reg, pb_prev_reg));
    ext_rise = pin_seen_reg & pa_sync_reg[irq_wake_pkg::PIN_BIT] &
               ~pa_prev_reg[irq_wake_pkg::PIN_BIT];
    ext_fall = pin_seen_reg & ~pa_sync_reg[irq_wake_pkg::PIN_BIT] &
               pa_prev_reg[irq_wake_pkg::PIN_BIT];
    // Reserved select 00 qualifies no edge
    unique case (edge_sel_reg)
      irq_wake_pkg::EDGE_RISE: ext_event = ext_rise; // R19
      irq_wake_pkg::EDGE_FALL: ext_event = ext_fall; // R19
      irq_wake_pkg::EDGE_BOTH: ext_event = ext_rise | ext_fall; // R19
      default:                 ext_event = 1'b0;
    endcase
    // Capture timer has no say in waking from idle
    wake_idle = port_change | basic_timer_ovf; // R5 R9
    warm_last = osc_is_rc ? 12'(WARM_RC - 1) : 12'(WARM_XTAL - 1); // R7
    warm_done = (warm_cnt_reg == warm_last);
  end

  // APB decode; registers answer in the access cycle
  logic        setup_ph, wr_en;
  logic [7:0]  idx;
  logic        mapped;
  logic [31:0] rd_mux;

  always_comb begin
    setup_ph = psel & ~penable;
    idx      = paddr[9:2];
    mapped   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
               ((idx == irq_wake_pkg::EDGE_CONFIG_IDX) ||
                (idx == irq_wake_pkg::REQ_FLAGS_IDX) ||
                (idx == irq_wake_pkg::ENABLES_IDX) ||
                (idx == irq_wake_pkg::OSC_MODE_IDX) ||
                (idx == irq_wake_pkg::GIE_STACK_IDX));
    wr_en    = psel & penable & pready & pwrite & ~pslverr;
    rd_mux   = 32'h0000_0000;
    unique case (idx)
      irq_wake_pkg::EDGE_CONFIG_IDX:
        rd_mux[irq_wake_pkg::EDGE_LO_BIT +: 2] = edge_sel_reg;
      irq_wake_pkg::REQ_FLAGS_IDX: rd_mux[7:0] = flags_reg;
      irq_wake_pkg::ENABLES_IDX:   rd_mux[7:0] = enables_reg;
      irq_wake_pkg::OSC_MODE_IDX: begin
        rd_mux[irq_wake_pkg::IDLE_REQ_BIT]  = idle_req_reg;
        rd_mux[irq_wake_pkg::SLEEP_REQ_BIT] = sleep_req_reg;
        rd_mux[irq_wake_pkg::SLOW_BIT]      = slow_reg;
        rd_mux[irq_wake_pkg::STOP_HX_BIT]   = stop_hx_reg;
      end
      irq_wake_pkg::GIE_STACK_IDX: begin
        rd_mux[irq_wake_pkg::GIE_BIT] = gie_reg;
        rd_mux[2:0]                   = level_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // Bus answer; one wait-free access phase per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      if (setup_ph && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Enables and edge select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_reg  <= 8'h00;
      edge_sel_reg <= irq_wake_pkg::EDGE_SEL_RST;
    end else if (wr_en) begin
      if (idx == irq_wake_pkg::ENABLES_IDX) begin
        enables_reg <= '0;
        enables_reg[irq_wake_pkg::PIN_BIT] <=
          pwdata[irq_wake_pkg::PIN_BIT]; // R13
        enables_reg[irq_wake_pkg::BASIC_BIT] <=
          pwdata[irq_wake_pkg::BASIC_BIT]; // R13
        enables_reg[irq_wake_pkg::CAPTURE_BIT] <=
          pwdata[irq_wake_pkg::CAPTURE_BIT]; // R13
      end
      if (idx == irq_wake_pkg::EDGE_CONFIG_IDX) begin
        edge_sel_reg <= pwdata[irq_wake_pkg::EDGE_LO_BIT +: 2];
      end
    end
  end

  // Request flags; a hardware event beats a software clear
  always_comb begin
    flags_next = flags_reg;
    if (wr_en && idx == irq_wake_pkg::REQ_FLAGS_IDX) begin
      flags_next = pwdata[7:0] & 8'h31; // R14
    end
    // Pin flag sets whatever the enable, also to latch a wake edge
    if (ext_event) begin
      flags_next[irq_wake_pkg::PIN_BIT] = 1'b1; // R18 R17
    end
    // Basic timer still counts in idle, not in power-down
    if (basic_timer_ovf && state_reg != irq_wake_pkg::ST_SLEEP &&
        state_reg != irq_wake_pkg::ST_WARMUP) begin
      flags_next[irq_wake_pkg::BASIC_BIT] = 1'b1; // R14 R3
    end
    if (capture_timer_ovf && state_reg == irq_wake_pkg::ST_RUN) begin
      flags_next[irq_wake_pkg::CAPTURE_BIT] = 1'b1; // R14 R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Vector decision at an instruction boundary
  assign take_irq = cpu_req.boundary && state_reg == irq_wake_pkg::ST_RUN &&
                    gie_reg && |(enables_reg & flags_reg); // R21 R15

  // Power-state sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      irq_wake_pkg::ST_RUN: begin
        if (sleep_req_reg) begin
          state_next = irq_wake_pkg::ST_SLEEP; // R20
        end else if (idle_req_reg) begin
          state_next = irq_wake_pkg::ST_IDLE; // R1
        end
      end
      irq_wake_pkg::ST_IDLE: begin
        if (wake_idle) begin
          state_next = irq_wake_pkg::ST_RUN; // R8
        end
      end
      irq_wake_pkg::ST_SLEEP: begin
        if (port_change) begin
          state_next = irq_wake_pkg::ST_WARMUP; // R6
        end
      end
      irq_wake_pkg::ST_WARMUP: begin
        if (warm_done) begin
          state_next = irq_wake_pkg::ST_RUN; // R7
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= irq_wake_pkg::ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Warm-up counter, cleared outside the warm-up state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt_reg <= 12'h000;
    end else if (state_reg == irq_wake_pkg::ST_WARMUP) begin
      warm_cnt_reg <= warm_cnt_reg + 12'h001; // R7
    end else begin
      warm_cnt_reg <= 12'h000;
    end
  end

  // Oscillator mode bits; wakeup clears the request bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_req_reg  <= 1'b0;
      sleep_req_reg <= 1'b0;
      slow_reg      <= 1'b0;
      stop_hx_reg   <= 1'b0;
    end else begin
      if (wr_en && idx == irq_wake_pkg::OSC_MODE_IDX) begin
        idle_req_reg  <= pwdata[irq_wake_pkg::IDLE_REQ_BIT];
        sleep_req_reg <= pwdata[irq_wake_pkg::SLEEP_REQ_BIT];
        slow_reg      <= pwdata[irq_wake_pkg::SLOW_BIT];
        stop_hx_reg   <= pwdata[irq_wake_pkg::STOP_HX_BIT];
      end
      // Slow bit is left alone so idle resumes the entry mode
      if (state_reg == irq_wake_pkg::ST_IDLE && wake_idle) begin
        idle_req_reg <= 1'b0; // R2 R4
      end
      if (state_reg == irq_wake_pkg::ST_WARMUP && warm_done) begin
        sleep_req_reg <= 1'b0; // R20
        idle_req_reg  <= 1'b0;
        slow_reg      <= 1'b0; // R6
        stop_hx_reg   <= 1'b0;
      end
    end
  end

  // Return address stack
  logic [13:0] stack_mem [STACK_DEPTH];

  always_ff @(posedge pclk) begin
    if (take_irq) begin
      stack_mem[level_reg] <= cpu_req.return_pc; // R11
    end
  end

  // Global enable and stack level; service clears, return sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gie_reg   <= 1'b0; // R15
      level_reg <= irq_wake_pkg::STACK_LEVEL_RST;
    end else if (take_irq) begin
      gie_reg   <= 1'b0; // R10
      level_reg <= level_reg - 3'h1; // R11
    end else if (cpu_req.return_from_irq) begin
      gie_reg   <= 1'b1; // R10
      level_reg <= level_reg + 3'h1; // R12
    end else if (wr_en && idx == irq_wake_pkg::GIE_STACK_IDX) begin
      gie_reg   <= pwdata[irq_wake_pkg::GIE_BIT];
      level_reg <= pwdata[2:0];
    end
  end

  // Context buffer, one level; flag bits 7 and 6 are not kept
  logic [7:0] acc_save_reg, flags_save_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_save_reg   <= 8'h00;
      flags_save_reg <= 8'h00;
    end else if (cpu_req.push) begin
      acc_save_reg   <= cpu_req.acc; // R16
      flags_save_reg <= cpu_req.flags & irq_wake_pkg::FLAG_SAVE_MASK; // R16
    end
  end

  // CPU answers, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_rsp <= '0;
      cpu_rsp.run <= 1'b1;
    end else begin
      cpu_rsp.run       <= (state_next == irq_wake_pkg::ST_RUN); // R1
      cpu_rsp.irq_taken <= take_irq;
      cpu_rsp.pc_load   <= take_irq | cpu_req.return_from_irq;
      if (take_irq) begin
        cpu_rsp.pc_value <= irq_wake_pkg::IRQ_VECTOR; // R11
      end else if (cpu_req.return_from_irq) begin
        cpu_rsp.pc_value <= stack_mem[level_reg + 3'h1]; // R12
      end
      if (cpu_req.pop) begin
        cpu_rsp.acc   <= acc_save_reg; // R16
        cpu_rsp.flags <= flags_save_reg;
      end
    end
  end

  // Function gating; the basic timer keeps running through idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      basic_timer_run <= 1'b1;
      functions_run   <= 1'b1;
      hs_osc_run      <= 1'b1;
    end else begin
      basic_timer_run <= (state_next == irq_wake_pkg::ST_RUN) ||
                         (state_next == irq_wake_pkg::ST_IDLE); // R3
      functions_run   <= (state_next == irq_wake_pkg::ST_RUN); // R3
      hs_osc_run      <= (state_next != irq_wake_pkg::ST_SLEEP) &&
                         !(stop_hx_reg && slow_reg); // R20
    end
  end

  // Cycles spent in warm-up, counted apart from the counter it checks
  logic [12:0] warm_seen_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_seen_reg <= 13'h0000;
    end else if (state_reg == irq_wake_pkg::ST_WARMUP) begin
      warm_seen_reg <= warm_seen_reg + 13'h0001;
    end else begin
      warm_seen_reg <= 13'h0000;
    end
  end

  // Checks
  AST_IDLE_ENTRY: assert property (@(posedge pclk) disable iff (!presetn) // R1
    state_reg == irq_wake_pkg::ST_RUN && idle_req_reg && !sleep_req_reg
    |=> state_reg == irq_wake_pkg::ST_IDLE ##0 !cpu_rsp.run)
    else $error("idle request did not stop execution");
  AST_IDLE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // R2
    state_reg == irq_wake_pkg::ST_IDLE && wake_idle
    |=> !idle_req_reg && slow_reg == $past(slow_reg))
    else $error("idle bit not cleared or mode lost on wakeup");
  AST_IDLE_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R3
    state_reg == irq_wake_pkg::ST_IDLE |-> basic_timer_run && !functions_run)
    else $error("wrong function gating in idle");
  AST_NO_WARM_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // R8
    state_reg == irq_wake_pkg::ST_IDLE && wake_idle
    |=> state_reg == irq_wake_pkg::ST_RUN ##0 cpu_rsp.run)
    else $error("idle wakeup was delayed");
  AST_CAPTURE_NO_WAKE: assert property (@(posedge pclk) // R9
    disable iff (!presetn)
    state_reg == irq_wake_pkg::ST_IDLE && capture_timer_ovf &&
    !port_change && !basic_timer_ovf |=> state_reg == irq_wake_pkg::ST_IDLE)
    else $error("capture overflow woke idle");
  AST_SLEEP_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R6
    state_reg == irq_wake_pkg::ST_SLEEP && !port_change
    |=> state_reg == irq_wake_pkg::ST_SLEEP)
    else $error("power-down left without port change");
  AST_WARM_TIME: assert property (@(posedge pclk) disable iff (!presetn) // R7
    state_reg == irq_wake_pkg::ST_WARMUP && state_next == irq_wake_pkg::ST_RUN
    |-> warm_seen_reg == (osc_is_rc ? 13'(WARM_RC - 1) : 13'(WARM_XTAL - 1))
    ##1 (state_reg == irq_wake_pkg::ST_RUN && !slow_reg && !sleep_req_reg))
    else $error("warm-up length or resume mode wrong");
  AST_WARM_BOUND: assert property (@(posedge pclk) disable iff (!presetn) // R7
    state_reg == irq_wake_pkg::ST_WARMUP |-> warm_cnt_reg <= warm_last)
    else $error("warm-up counter overran");
  AST_VECTOR: assert property (@(posedge pclk) disable iff (!presetn) // R11
    cpu_rsp.irq_taken |-> cpu_rsp.pc_load && !gie_reg &&
    cpu_rsp.pc_value == irq_wake_pkg::IRQ_VECTOR &&
    level_reg == $past(level_reg) - 3'h1)
    else $error("vectoring did not load 8 or clear the global enable");
  AST_GIE_GATE: assert property (@(posedge pclk) disable iff (!presetn) // R15
    cpu_rsp.irq_taken |-> $past(gie_reg) &&
    |($past(enables_reg) & $past(flags_reg)))
    else $error("interrupt taken while not allowed");
  AST_RETURN: assert property (@(posedge pclk) disable iff (!presetn) // R10
    cpu_req.return_from_irq && !take_irq |=> gie_reg && cpu_rsp.pc_load)
    else $error("return did not restore global enable");
  AST_PIN_FLAG: assert property (@(posedge pclk) disable iff (!presetn) // R18
    ext_event |=> flags_reg[irq_wake_pkg::PIN_BIT])
    else $error("pin flag missed an edge");

endmodule
`default_nettype wire

//--- verif/cpu_model.sv
// Behavioural CPU core on the far side of the interrupt block
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Block interface
  input  wire irq_wake_pkg::cpu_rsp_t cpu_rsp,
  output irq_wake_pkg::cpu_req_t      cpu_req
);
  initial cpu_req = '0;

  // Boundary only while execution is allowed; stale pc inverted after
  task automatic boundary(input logic [13:0] pc);
    while (cpu_rsp.run !== 1'b1) @(posedge pclk);
    @(posedge pclk);
    cpu_req.boundary <= 1'b1;
    cpu_req.return_pc <= pc;
    @(posedge pclk);
    cpu_req.boundary <= 1'b0;
    cpu_req.return_pc <= ~pc;
  endtask

  // One-cycle strobes: 0 return, 1 save context, 2 restore context
  task automatic strobe(input int kind, input logic [7:0] a, f);
    @(posedge pclk);
    case (kind)
      0: cpu_req.return_from_irq <= 1'b1;
      1: begin
        cpu_req.push <= 1'b1;
        cpu_req.acc <= a;
        cpu_req.flags <= f;
      end
      default: cpu_req.pop <= 1'b1;
    endcase
    @(posedge pclk);
    cpu_req.return_from_irq <= 1'b0;
    cpu_req.push <= 1'b0;
    cpu_req.pop <= 1'b0;
    cpu_req.acc <= ~a;
    cpu_req.flags <= ~f;
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the interrupt and wakeup block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int         WX     = 64;
  localparam int         WR     = 32;
  localparam logic [7:0] IX_EDG = irq_wake_pkg::EDGE_CONFIG_IDX;
  localparam logic [7:0] IX_REQ = irq_wake_pkg::REQ_FLAGS_IDX;
  localparam logic [7:0] IX_EN  = irq_wake_pkg::ENABLES_IDX;
  localparam logic [7:0] IX_OSC = irq_wake_pkg::OSC_MODE_IDX;
  localparam logic [7:0] IX_GIE = irq_wake_pkg::GIE_STACK_IDX;
  logic                   pclk, presetn, psel, penable, pwrite;
  logic                   pready, pslverr, bt_ovf, ct_ovf, osc_is_rc;
  logic                   bt_run, fn_run, hs_run;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic [7:0]             port_a, port_b, ra, rf;
  logic [13:0]            rpc;
  irq_wake_pkg::cpu_req_t cpu_req;
  irq_wake_pkg::cpu_rsp_t cpu_rsp;
  logic [32:0]            exp_rd[$];
  logic [14:0]            exp_pc[$];
  int                     bad_count, comparisons;

  irq_and_idle_wakeup_ctrl #(.WARM_XTAL(WX), .WARM_RC(WR)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
    .cpu_rsp(cpu_rsp), .port_a(port_a), .port_b(port_b),
    .basic_timer_ovf(bt_ovf), .capture_timer_ovf(ct_ovf),
    .osc_is_rc(osc_is_rc), .basic_timer_run(bt_run),
    .functions_run(fn_run), .hs_osc_run(hs_run));
  cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .cpu_rsp(cpu_rsp),
    .cpu_req(cpu_req));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  task automatic check(input string nm, input logic [32:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [11:0] addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // APB transfer; request held until pready seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, addr(idx), d);
  endtask

  // Expected {error, data} noted; the monitor compares it
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_rd.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pulse(input logic basic);
    @(posedge pclk);
    bt_ovf <= basic;
    ct_ovf <= ~basic;
    @(posedge pclk);
    bt_ovf <= 1'b0;
    ct_ovf <= 1'b0;
  endtask

  // Counts edges until run reaches v; count must lie in [lo, hi]
  task automatic wait_run(input logic v, input int lo, hi);
    int n;
    n = 0;
    while (cpu_rsp.run !== v && n <= hi) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check("run latency", 33'(n >= lo && n <= hi), 33'h1);
  endtask

  // Monitor: oldest note against each read answer and pc load
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("read", exp_rd.pop_front(), {pslverr, prdata});
    if (presetn && cpu_rsp.pc_load === 1'b1) begin
      if (exp_pc.size() == 0)
        check("stray pc load", 33'h0, 33'h1);
      else
        check("pc", 33'(exp_pc.pop_front()),
              33'({cpu_rsp.irq_taken, cpu_rsp.pc_value}));
    end
  end

  task automatic summarize();
    bad_count += exp_rd.size() + exp_pc.size();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, bt_ovf, ct_ovf, osc_is_rc} = '0;
    paddr = '0;
    pwdata = '0;
    port_a = 8'hff;
    port_b = 8'hff;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(32'he3b11f42));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    tick(3);
    // Reset values and an unmapped word
    rd(addr(IX_EDG), 33'h10);
    rd(addr(IX_REQ), 33'h0);
    rd(addr(IX_EN), 33'h0);
    rd(addr(IX_OSC), 33'h0);
    rd(addr(IX_GIE), 33'h07);
    rd(12'h000, 33'h1_0000_0000);
    // Every edge select, pin disabled: flag still sets
    for (int es = 1; es < 4; es++) begin
      wr(IX_EDG, 32'(es << 3));
      wr(IX_REQ, 32'h0000_0000);
      for (int k = 1; k >= 0; k--) begin
        @(posedge pclk);
        port_a[0] <= ~port_a[0];
        tick(6);
        rd(addr(IX_REQ), 33'((es >> k) & 1));
        wr(IX_REQ, 32'h0000_0000);
      end
    end
    // Service refused without global enable, then taken and returned
    wr(IX_EN, 32'h0000_0031);
    pulse(1'b1);
    rd(addr(IX_REQ), 33'h10);
    u_cpu.boundary(14'h0100);
    tick(3);
    wr(IX_GIE, 32'h0000_0087);
    rpc = 14'($urandom);
    exp_pc.push_back({1'b1, irq_wake_pkg::IRQ_VECTOR});
    u_cpu.boundary(rpc);
    tick(3);
    rd(addr(IX_GIE), 33'h06);
    wr(IX_REQ, 32'h0000_0000);
    exp_pc.push_back({1'b0, rpc});
    u_cpu.strobe(0, 8'h00, 8'h00);
    tick(3);
    rd(addr(IX_GIE), 33'h87);
    wr(IX_EN, 32'h0000_0001);
    pulse(1'b1);
    u_cpu.boundary(14'h0200);
    tick(3);
    wr(IX_GIE, 32'h0000_0007);
    // Context save and restore with random contents
    ra = 8'($urandom);
    rf = 8'($urandom);
    u_cpu.strobe(1, ra, rf);
    u_cpu.strobe(2, 8'h00, 8'h00);
    tick(1);
    check("acc", 33'(ra), 33'(cpu_rsp.acc));
    check("flags", 33'(rf & 8'h3f), 33'(cpu_rsp.flags));
    // Idle from normal: capture overflow ignored, basic overflow wakes
    wr(IX_OSC, 32'h0000_0010);
    wait_run(1'b0, 0, 2);
    check("gating", 33'h2, {bt_run, fn_run});
    pulse(1'b0);
    tick(4);
    check("idle run", 33'h0, 33'(cpu_rsp.run));
    pulse(1'b1);
    wait_run(1'b1, 0, 2);
    rd(addr(IX_OSC), 33'h0);
    // Idle from slow, woken by a port change
    wr(IX_OSC, 32'h0000_0004);
    wr(IX_OSC, 32'h0000_0014);
    wait_run(1'b0, 0, 2);
    @(posedge pclk);
    port_b[3] <= 1'b0;
    wait_run(1'b1, 1, 6);
    rd(addr(IX_OSC), 33'h04);
    // Power-down with crystal then RC warm-up
    for (int rc = 0; rc < 2; rc++) begin
      osc_is_rc <= 1'(rc);
      wr(IX_OSC, 32'h0000_0008);
      wait_run(1'b0, 0, 2);
      check("hs osc", 33'h0, 33'(hs_run));
      pulse(1'b1);
      tick(4);
      check("sleep run", 33'h0, 33'(cpu_rsp.run));
      @(posedge pclk);
      port_a[0] <= ~port_a[0];
      wait_run(1'b1, rc ? WR : WX, (rc ? WR : WX) + 8);
      rd(addr(IX_OSC), 33'h0);
    end
    tick(4);
    summarize();
  end
endmodule
`default_nettype wire
